// *** common/efs_pkg.sv ***
// register map, field layout and timing constants of the e1 sync/event block
package efs_pkg;
  // register indices; the byte address is four times the index
  localparam logic [9:0] IDX_MODE = 10'h04e;
  localparam logic [9:0] IDX_STATE = 10'h04f;
  localparam logic [9:0] IDX_SYNC_EN = 10'h050;
  localparam logic [9:0] IDX_EVT_EN = 10'h051;
  localparam logic [9:0] IDX_SYNC_FLG = 10'h052;
  localparam logic [9:0] IDX_EVT_FLG = 10'h053;

  // count-criterion selects in the mode register
  localparam int MODE_NFAS_BIT = 4;
  localparam int MODE_WORD_BIT = 3;

  // reset values
  localparam logic [7:0] MODE_RST = 8'he0;
  localparam logic [7:0] EN_RST = 8'h00;
  localparam logic [7:0] FLG_RST = 8'h00;
  localparam logic [4:0] STATE_RST = 5'h0d;
  localparam logic [7:0] SYNC_EN_MASK = 8'h3f;

  // state and sync-change flag positions
  localparam int ST_BASIC = 0;
  localparam int ST_OFFLINE = 1;
  localparam int ST_CRCMF = 2;
  localparam int ST_SIGMF = 3;
  localparam int ST_IWK = 4;
  localparam int SYNC_EXCESS = 5;

  // event flag positions
  localparam int EV_ALIGN = 0;
  localparam int EV_WORD = 1;
  localparam int EV_CRC = 2;
  localparam int EV_CRCMF_ERR = 3;
  localparam int EV_CRCMF_BND = 4;
  localparam int EV_SIGMF_ERR = 5;
  localparam int EV_SUBMF_BND = 6;
  localparam int EV_SIGMF_BND = 7;

  // alignment words and their bit positions in the frame
  localparam logic [6:0] FAS_WORD = 7'h1b;
  localparam logic [5:0] CRCMF_WORD = 6'h0b;
  localparam logic [3:0] SIGMF_WORD = 4'h0;
  localparam logic [7:0] POS_SI = 8'h00;
  localparam logic [7:0] POS_NFAS_BIT = 8'h01;
  localparam logic [7:0] POS_FAS_LAST = 8'h07;
  localparam logic [7:0] POS_TS16 = 8'h80;
  localparam logic [7:0] POS_TS16_LAST = 8'h83;
  localparam logic [3:0] CRCMF_FIRST_FRM = 4'h1;
  localparam logic [3:0] CRCMF_LAST_FRM = 4'hb;
  localparam logic [3:0] CRC_POLY = 4'h3;
  localparam logic [1:0] SMF_READY = 2'h2;

  // excessive crc-4 error window
  localparam logic [9:0] EXC_THRESH = 10'h393;
  localparam int unsigned EXC_WIN_S = 1;
  localparam int unsigned CLK_HZ = 20000000;
  localparam int unsigned EXC_WIN_CYC = EXC_WIN_S * CLK_HZ;
endpackage : efs_pkg

// *** common/efs_reg_if.sv ***
// register access signals between the bus front end and the core
`timescale 1ns/1ns
interface efs_reg_if;
  logic [9:0] idx;
  logic wr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport bus (output idx, output wr, output wdata, input rdata);
  modport core (input idx, input wr, input wdata, output rdata);
endinterface : efs_reg_if

// *** rtl/efs_bus_slave.sv ***
// avalon-mm slave front end with one wait state per access
`timescale 1ns/1ns
module efs_bus_slave (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  efs_reg_if.bus regs
);
  logic req;
  logic done_r;
  logic [7:0] rdata_r;

  assign req = avs_read_in | avs_write_in;
  // a frozen clock enable must not let the master finish
  assign avs_waitrequest_out = req & ~(done_r & ce_in);
  assign regs.idx = avs_address_in[11:2];
  // writes land on the edge that ends the wait; only lane 0 holds data
  assign regs.wr = avs_write_in & done_r & avs_byteenable_in[0];
  assign regs.wdata = avs_writedata_in[7:0];
  assign avs_readdata_out = {24'h000000, rdata_r};

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      done_r <= 1'b0;
    end else if (ce_in) begin
      done_r <= req & ~done_r;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      rdata_r <= 8'h00;
    end else if (ce_in && avs_read_in && !done_r) begin
      rdata_r <= regs.rdata;
    end
  end
endmodule : efs_bus_slave

// *** rtl/efs_top.sv ***
// e1 receive sync status, event detection and interrupt logic
`timescale 1ns/1ns
// Function
// - four sync flags read 1 while out of sync, 0 while in sync
// - each event flag has an enable; only enabled flags reach the interrupt
// - any toggle of a sync or interworking flag sets its change flag
// - flags stay set until software writes one; writing zero changes nothing
// - count crc-4 errors per one-second window; flag excess at 915
// - excess detection suspended while crc multiframe is unlocked
// - flag first bit of each signaling multiframe, only while locked
// - flag first bit of each crc sub-multiframe, only while locked
// - flag first bit of each crc multiframe, only while locked
// - signaling alignment word mismatch against 0000 gives one error event
// - crc multiframe alignment bits mismatch against 001011 gives one event
// - crc-4 of each sub-multiframe checked against next one's carried bits
// - frame word error event per selected criterion while basic frame locked
// - criterion selects fas bit, fas word, plus nfas errors
// - flag when a newly found frame position differs from the previous
module efs_top #(
  parameter int unsigned WIN_CYC = efs_pkg::EXC_WIN_CYC
) (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  input wire logic basic_frame_unlocked_in,
  input wire logic offline_frame_unlocked_in,
  input wire logic crcmf_unlocked_in,
  input wire logic sigmf_unlocked_in,
  input wire logic interwork_active_in,
  input wire logic rx_bit_in,
  input wire logic rx_bit_en_in,
  input wire logic frame_start_in,
  input wire logic fas_frame_in,
  input wire logic crcmf_start_in,
  input wire logic sigmf_start_in,
  input wire logic align_found_in,
  input wire logic [7:0] align_pos_in,
  output logic [2:0] fas_err_num_out,
  output logic int_n_out
);
  localparam int WIN_W = $clog2(WIN_CYC + 1);

  function automatic logic hit(input logic [9:0] idx, input logic [9:0] want);
    return idx == want;
  endfunction : hit

  // set wins over a clear arriving in the same cycle
  function automatic logic [7:0] w1c(input logic [7:0] flg, input logic [7:0] clr, input logic [7:0] set);
    return (flg & ~clr) | set;
  endfunction : w1c

  function automatic logic [3:0] crc4_step(input logic [3:0] crc, input logic din);
    return {crc[2:0], 1'b0} ^ ((crc[3] ^ din) ? efs_pkg::CRC_POLY : 4'h0);
  endfunction : crc4_step

  // ********************************************
  // register access
  // ********************************************
  efs_reg_if regs ();

  efs_bus_slave u_bus (
    .core_clk_in(core_clk_in),
    .rstn_in(rstn_in),
    .ce_in(ce_in),
    .avs_address_in(avs_address_in),
    .avs_read_in(avs_read_in),
    .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in),
    .avs_byteenable_in(avs_byteenable_in),
    .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out),
    .regs(regs)
  );

  logic [7:0] mode_r;
  logic [7:0] sync_en_r;
  logic [7:0] evt_en_r;
  logic [7:0] sync_flg_r;
  logic [7:0] evt_flg_r;
  logic [4:0] state_now;
  logic [4:0] state_prev_r;
  logic [7:0] sync_set;
  logic [7:0] evt_set;
  logic [7:0] sync_clr;
  logic [7:0] evt_clr;

  assign state_now = {interwork_active_in, sigmf_unlocked_in, crcmf_unlocked_in,
                      offline_frame_unlocked_in, basic_frame_unlocked_in};

  always_comb begin
    regs.rdata = 8'h00;
    case (regs.idx)
      efs_pkg::IDX_MODE: regs.rdata = mode_r;
      efs_pkg::IDX_STATE: regs.rdata = {3'h0, state_now};
      efs_pkg::IDX_SYNC_EN: regs.rdata = sync_en_r;
      efs_pkg::IDX_EVT_EN: regs.rdata = evt_en_r;
      efs_pkg::IDX_SYNC_FLG: regs.rdata = sync_flg_r;
      efs_pkg::IDX_EVT_FLG: regs.rdata = evt_flg_r;
      default: regs.rdata = 8'h00;
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      mode_r <= efs_pkg::MODE_RST;
    end else if (ce_in && regs.wr && hit(regs.idx, efs_pkg::IDX_MODE)) begin
      mode_r <= regs.wdata;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sync_en_r <= efs_pkg::EN_RST;
      evt_en_r <= efs_pkg::EN_RST;
    end else if (ce_in && regs.wr) begin
      if (hit(regs.idx, efs_pkg::IDX_SYNC_EN)) begin
        sync_en_r <= regs.wdata & efs_pkg::SYNC_EN_MASK;
      end
      if (hit(regs.idx, efs_pkg::IDX_EVT_EN)) begin
        evt_en_r <= regs.wdata;
      end
    end
  end

  // ********************************************
  // bit position tracking
  // ********************************************
  logic bit_en;
  logic [7:0] pos_r;
  logic [7:0] pos;
  logic [3:0] cfrm_r;
  logic [3:0] cfrm;
  logic cas0_r;
  logic cas0;

  // the line runs far slower than the core; work happens on bit strobes
  assign bit_en = ce_in & rx_bit_en_in;

  always_comb begin
    pos = pos_r + 8'h01;
    cfrm = cfrm_r;
    cas0 = cas0_r;
    if (frame_start_in) begin
      pos = 8'h00;
      cfrm = crcmf_start_in ? 4'h0 : cfrm_r + 4'h1;
      cas0 = sigmf_start_in;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      pos_r <= 8'h00;
      cfrm_r <= 4'h0;
      cas0_r <= 1'b0;
    end else if (bit_en) begin
      pos_r <= pos;
      cfrm_r <= cfrm;
      cas0_r <= cas0;
    end
  end

  // ********************************************
  // frame word errors
  // ********************************************
  logic fas_bad;
  logic [2:0] fas_miss_r;
  logic [2:0] fas_miss;
  logic fas_done;
  logic nfas_done;
  logic [2:0] word_ev_num;

  assign fas_bad = rx_bit_in ^ efs_pkg::FAS_WORD[3'(3'h7 - pos[2:0])];
  assign fas_miss = fas_miss_r + {2'h0, fas_bad};
  assign fas_done = bit_en & fas_frame_in & (pos == efs_pkg::POS_FAS_LAST);
  assign nfas_done = bit_en & ~fas_frame_in & (pos == efs_pkg::POS_NFAS_BIT);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fas_miss_r <= 3'h0;
    end else if (bit_en) begin
      if (pos == efs_pkg::POS_SI) begin
        fas_miss_r <= 3'h0;
      end else if (fas_frame_in && pos <= efs_pkg::POS_FAS_LAST) begin
        fas_miss_r <= fas_miss;
      end
    end
  end

  always_comb begin
    word_ev_num = 3'h0;
    if (fas_done) begin
      word_ev_num = mode_r[efs_pkg::MODE_WORD_BIT] ? {2'h0, fas_miss != 3'h0} : fas_miss;
    end else if (nfas_done && mode_r[efs_pkg::MODE_NFAS_BIT] && !rx_bit_in) begin
      word_ev_num = 3'h1;
    end
    if (basic_frame_unlocked_in) begin
      word_ev_num = 3'h0;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      fas_err_num_out <= 3'h0;
    end else if (ce_in) begin
      fas_err_num_out <= word_ev_num;
    end
  end

  // ********************************************
  // crc multiframe alignment and crc-4
  // ********************************************
  logic crcmf_slot;
  logic crcmf_bad;
  logic crcmf_miss_r;
  logic smf_start;
  logic c_slot;
  logic [3:0] crc_r;
  logic [3:0] crc_prev_r;
  logic [3:0] c_rx_r;
  logic [1:0] smf_seen_r;
  logic crc_err;

  assign crcmf_slot = bit_en & (pos == efs_pkg::POS_SI) & cfrm[0] & (cfrm <= efs_pkg::CRCMF_LAST_FRM);
  assign crcmf_bad = rx_bit_in ^ efs_pkg::CRCMF_WORD[3'(3'h5 - cfrm[3:1])];
  assign smf_start = bit_en & frame_start_in & (cfrm[2:0] == 3'h0);
  assign c_slot = ~cfrm[0] & (pos == efs_pkg::POS_SI);
  // carried bits of one block against the sum of the block before
  assign crc_err = smf_start & (smf_seen_r == efs_pkg::SMF_READY) & (c_rx_r != crc_prev_r) & ~crcmf_unlocked_in;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      crcmf_miss_r <= 1'b0;
    end else if (crcmf_slot) begin
      crcmf_miss_r <= (cfrm == efs_pkg::CRCMF_FIRST_FRM) ? crcmf_bad : crcmf_miss_r | crcmf_bad;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      crc_r <= 4'h0;
      crc_prev_r <= 4'h0;
      c_rx_r <= 4'h0;
    end else if (smf_start) begin
      crc_prev_r <= crc_r;
      crc_r <= 4'h0;
      c_rx_r <= {3'h0, rx_bit_in};
    end else if (bit_en) begin
      crc_r <= crc4_step(crc_r, c_slot ? 1'b0 : rx_bit_in);
      if (c_slot) begin
        c_rx_r <= {c_rx_r[2:0], rx_bit_in};
      end
    end
  end

  // a comparison needs one whole block summed and the next one received
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      smf_seen_r <= 2'h0;
    end else if (ce_in && crcmf_unlocked_in) begin
      smf_seen_r <= 2'h0;
    end else if (smf_start && smf_seen_r != efs_pkg::SMF_READY) begin
      smf_seen_r <= smf_seen_r + 2'h1;
    end
  end

  // ********************************************
  // signaling multiframe alignment
  // ********************************************
  logic sig_slot;
  logic sig_bad;
  logic sig_miss_r;

  assign sig_slot = bit_en & cas0 & (pos >= efs_pkg::POS_TS16) & (pos <= efs_pkg::POS_TS16_LAST);
  assign sig_bad = rx_bit_in ^ efs_pkg::SIGMF_WORD[2'(efs_pkg::POS_TS16_LAST - pos)];

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sig_miss_r <= 1'b0;
    end else if (sig_slot) begin
      sig_miss_r <= (pos == efs_pkg::POS_TS16) ? sig_bad : sig_miss_r | sig_bad;
    end
  end

  // ********************************************
  // excessive crc-4 errors
  // ********************************************
  logic [WIN_W-1:0] win_cnt_r;
  logic [9:0] crc_cnt_r;
  logic win_end;
  logic excess_ev;

  assign win_end = win_cnt_r == WIN_W'(WIN_CYC - 1);
  // one event when the window count reaches the threshold
  assign excess_ev = crc_err & ~win_end & (crc_cnt_r == efs_pkg::EXC_THRESH - 10'h001);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      win_cnt_r <= '0;
      crc_cnt_r <= 10'h000;
    end else if (ce_in) begin
      // windows restart from zero once lock returns
      if (crcmf_unlocked_in) begin
        win_cnt_r <= '0;
        crc_cnt_r <= 10'h000;
      end else if (win_end) begin
        win_cnt_r <= '0;
        crc_cnt_r <= {9'h000, crc_err};
      end else begin
        win_cnt_r <= win_cnt_r + WIN_W'(1);
        if (crc_err && crc_cnt_r != efs_pkg::EXC_THRESH) begin
          crc_cnt_r <= crc_cnt_r + 10'h001;
        end
      end
    end
  end

  // ********************************************
  // alignment position change
  // ********************************************
  logic [7:0] apos_r;
  logic apos_ok_r;
  logic align_ev;

  // the first position found has nothing to differ from
  assign align_ev = ce_in & align_found_in & apos_ok_r & (align_pos_in != apos_r);

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      apos_r <= 8'h00;
      apos_ok_r <= 1'b0;
    end else if (ce_in && align_found_in) begin
      apos_r <= align_pos_in;
      apos_ok_r <= 1'b1;
    end
  end

  // ********************************************
  // event and change flags
  // ********************************************
  always_comb begin
    evt_set = 8'h00;
    evt_set[efs_pkg::EV_SIGMF_BND] = bit_en & frame_start_in & sigmf_start_in & ~sigmf_unlocked_in;
    evt_set[efs_pkg::EV_SUBMF_BND] = smf_start & ~crcmf_unlocked_in;
    evt_set[efs_pkg::EV_CRCMF_BND] = bit_en & frame_start_in & crcmf_start_in & ~crcmf_unlocked_in;
    // one error per signaling alignment word
    evt_set[efs_pkg::EV_SIGMF_ERR] = sig_slot & (pos == efs_pkg::POS_TS16_LAST) & (sig_miss_r | sig_bad) &
                                     ~sigmf_unlocked_in;
    // one error per crc multiframe word
    evt_set[efs_pkg::EV_CRCMF_ERR] = crcmf_slot & (cfrm == efs_pkg::CRCMF_LAST_FRM) &
                                     (crcmf_miss_r | crcmf_bad) & ~crcmf_unlocked_in;
    evt_set[efs_pkg::EV_CRC] = crc_err;
    evt_set[efs_pkg::EV_WORD] = word_ev_num != 3'h0;
    evt_set[efs_pkg::EV_ALIGN] = align_ev;
  end

  // both directions of each status bit
  assign sync_set = {3'h0, ce_in ? (state_now ^ state_prev_r) : 5'h00} |
                    {2'h0, excess_ev, 5'h00};

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      state_prev_r <= efs_pkg::STATE_RST;
    end else if (ce_in) begin
      state_prev_r <= state_now;
    end
  end

  assign sync_clr = (regs.wr && hit(regs.idx, efs_pkg::IDX_SYNC_FLG)) ? regs.wdata : 8'h00;
  assign evt_clr = (regs.wr && hit(regs.idx, efs_pkg::IDX_EVT_FLG)) ? regs.wdata : 8'h00;

  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      sync_flg_r <= efs_pkg::FLG_RST;
      evt_flg_r <= efs_pkg::FLG_RST;
    end else if (ce_in) begin
      // write one clears, write zero keeps
      sync_flg_r <= w1c(sync_flg_r, sync_clr & efs_pkg::SYNC_EN_MASK, sync_set);
      evt_flg_r <= w1c(evt_flg_r, evt_clr, evt_set);
    end
  end

  // ********************************************
  // interrupt
  // ********************************************
  always_ff @(posedge core_clk_in) begin
    if (!rstn_in) begin
      int_n_out <= 1'b1;
    end else if (ce_in) begin
      // only enabled flags pull the line low
      int_n_out <= ~(|(sync_flg_r & sync_en_r) | |(evt_flg_r & evt_en_r));
    end
  end
endmodule : efs_top

// *** tb/efs_assertions.sv ***
// port-level assertions for the e1 sync/event block
`timescale 1ns/1ns
module efs_assertions (
  input wire logic core_clk_in,
  input wire logic rstn_in,
  input wire logic ce_in,
  input wire logic [11:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic avs_waitrequest_out,
  input wire logic basic_frame_unlocked_in,
  input wire logic offline_frame_unlocked_in,
  input wire logic crcmf_unlocked_in,
  input wire logic sigmf_unlocked_in,
  input wire logic interwork_active_in,
  input wire logic rx_bit_en_in,
  input wire logic [2:0] fas_err_num_out,
  input wire logic int_n_out
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rstn_in);
  logic req;
  assign req = avs_read_in | avs_write_in;
  // ****************
  // bus handshake
  // ****************
  property p_first_wait;
    $rose(req) |-> avs_waitrequest_out;
  endproperty
  a_first_wait: assert property (p_first_wait) else $error("new request not held off");
  property p_one_wait;
    req && avs_waitrequest_out && ce_in |=> !req || !avs_waitrequest_out;
  endproperty
  a_one_wait: assert property (p_one_wait) else $error("more than one wait state");
  property p_idle;
    !req |-> !avs_waitrequest_out;
  endproperty
  a_idle: assert property (p_idle) else $error("wait asserted with no request");
  property p_rd_hi;
    avs_read_in && !avs_waitrequest_out |-> avs_readdata_out[31:8] == 24'h0;
  endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read data not zero");
  property p_state_rd;
    avs_read_in && !avs_waitrequest_out && avs_address_in[11:2] == efs_pkg::IDX_STATE |->
      avs_readdata_out[7:0] == {3'h0, $past(interwork_active_in), $past(sigmf_unlocked_in),
      $past(crcmf_unlocked_in), $past(offline_frame_unlocked_in), $past(basic_frame_unlocked_in)};
  endproperty
  a_state_rd: assert property (p_state_rd) else $error("state read differs from sync inputs");
  // ****************
  // line side and interrupt
  // ****************
  property p_err_src;
    fas_err_num_out != 3'h0 |-> $past(rx_bit_en_in) && !$past(basic_frame_unlocked_in);
  endproperty
  a_err_src: assert property (p_err_src) else $error("word error without locked bit");
  property p_err_pulse;
    fas_err_num_out != 3'h0 |=> fas_err_num_out == 3'h0;
  endproperty
  a_err_pulse: assert property (p_err_pulse) else $error("error count held over");
  property p_int_rise;
    $rose(int_n_out) |-> $past(avs_write_in, 2) || $past(rstn_in) == 1'b0;
  endproperty
  a_int_rise: assert property (p_int_rise) else $error("interrupt released without write");
endmodule : efs_assertions

// *** tb/efs_line_model.sv ***
// remote transmitter model: framed e1 bit stream with injectable faults
`timescale 1ns/1ns
module efs_line_model (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic run_in,
  input wire logic [6:0] fas_flip_in,
  input wire logic nfas_flip_in,
  output logic rx_bit_out,
  output logic rx_bit_en_out,
  output logic frame_start_out,
  output logic fas_frame_out,
  output logic mf_start_out
);
  logic [7:0] pos_r;
  logic [3:0] frm_r;
  logic bit_nxt;
  always_comb begin
    bit_nxt = 1'b0;
    if (pos_r == 8'h00 && frm_r[0]) begin
      bit_nxt = frm_r <= efs_pkg::CRCMF_LAST_FRM ? efs_pkg::CRCMF_WORD[3'd5 - frm_r[3:1]] : 1'b1;
    end else if (pos_r >= 8'h01 && pos_r <= 8'h07 && !frm_r[0]) begin
      bit_nxt = efs_pkg::FAS_WORD[8'h07 - pos_r] ^ fas_flip_in[8'h07 - pos_r];
    end else if (pos_r == 8'h01) begin
      bit_nxt = ~nfas_flip_in;
    end
  end
  // payload and sig word stay zero
  always_ff @(posedge clk_in) begin
    if (!rstn_in) begin
      rx_bit_out <= 1'b0;
    end else if (!run_in) begin
      rx_bit_out <= ~rx_bit_out;
    end else begin
      rx_bit_out <= bit_nxt;
    end
  end
  always_ff @(posedge clk_in) begin
    if (!rstn_in || !run_in) begin
      pos_r <= 8'h00;
      frm_r <= 4'h0;
      rx_bit_en_out <= 1'b0;
      frame_start_out <= 1'b0;
      fas_frame_out <= 1'b0;
      mf_start_out <= 1'b0;
    end else begin
      rx_bit_en_out <= 1'b1;
      frame_start_out <= pos_r == 8'h00;
      fas_frame_out <= !frm_r[0];
      mf_start_out <= pos_r == 8'h00 && frm_r == 4'h0;
      pos_r <= pos_r + 8'h01;
      frm_r <= pos_r == 8'hff ? frm_r + 4'h1 : frm_r;
    end
  end
endmodule : efs_line_model

// *** tb/tb_efs_top.sv ***
// self-checking bench for the e1 sync/event block
`timescale 1ns/1ns
module tb_efs_top;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic ce = 1'b1;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [11:0] addr = 12'h000;
  logic [31:0] wdata = 32'h0;
  logic [31:0] rdata;
  logic waitreq;
  logic [4:0] sy = 5'h0d;
  logic run = 1'b0;
  logic [6:0] flip = 7'h00;
  logic nflip = 1'b0;
  logic afound = 1'b0;
  logic [7:0] apos = 8'h00;
  logic [2:0] errn;
  logic int_n;
  logic lbit, len, lfs, lfas, lmf;
  logic [7:0] q;
  logic [15:0] acc;
  int n_mismatch = 0;
  int total_checks = 0;
  int cyc = 0;
  int e;
  always #25 clk = ~clk;
  efs_top #(.WIN_CYC(2000)) u_efs_top (.core_clk_in(clk), .rstn_in(rstn), .ce_in(ce),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'h1), .avs_readdata_out(rdata), .avs_waitrequest_out(waitreq),
    .basic_frame_unlocked_in(sy[0]), .offline_frame_unlocked_in(sy[1]), .crcmf_unlocked_in(sy[2]),
    .sigmf_unlocked_in(sy[3]), .interwork_active_in(sy[4]), .rx_bit_in(lbit), .rx_bit_en_in(len),
    .frame_start_in(lfs), .fas_frame_in(lfas), .crcmf_start_in(lmf), .sigmf_start_in(lmf),
    .align_found_in(afound), .align_pos_in(apos), .fas_err_num_out(errn), .int_n_out(int_n));
  efs_line_model u_efs_line_model (.clk_in(clk), .rstn_in(rstn), .run_in(run), .fas_flip_in(flip),
    .nfas_flip_in(nflip), .rx_bit_out(lbit), .rx_bit_en_out(len), .frame_start_out(lfs),
    .fas_frame_out(lfas), .mf_start_out(lmf));
  // ****************
  // tasks
  // ****************
  task automatic results();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : results
  task automatic chk(input string nm, input logic [15:0] x, input logic [15:0] g);
    total_checks++;
    if (g !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chk
  task automatic pin(input logic x, input string nm);
    total_checks++;
    if (int_n !== x) begin
      n_mismatch++;
      $display("[FAIL] %s expected %b seen %b", nm, x, int_n);
    end
  endtask : pin
  // holds the request until waitrequest is seen low at a rising edge
  task automatic bus(input logic w, input logic [9:0] idx, input logic [7:0] d, output logic [7:0] v);
    int n;
    n = 0;
    @(posedge clk);
    addr <= {idx, 2'b00};
    rd <= ~w;
    wr <= w;
    wdata <= {24'h0, d};
    do begin
      @(posedge clk);
      n++;
    end while (waitreq !== 1'b0 && n < 20);
    v = rdata[7:0];
    if (n >= 20) n_mismatch++;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask : bus
  task automatic rdchk(input logic [9:0] idx, input logic [7:0] x, input string nm);
    logic [7:0] v;
    bus(1'b0, idx, 8'h00, v);
    chk(nm, 16'(x), 16'(v));
  endtask : rdchk
  task automatic run_mf();
    acc = 16'h0;
    run <= 1'b1;
    repeat (4100) begin
      @(posedge clk);
      acc = acc + 16'(errn);
    end
    run <= 1'b0;
  endtask : run_mf
  always @(posedge clk) begin
    cyc++;
    if (cyc == 60000) begin
      n_mismatch++;
      results();
    end
  end
  // ****************
  // tests
  // ****************
  initial begin
    void'($urandom(42));
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rdchk(efs_pkg::IDX_MODE, efs_pkg::MODE_RST, "mode");
    rdchk(efs_pkg::IDX_STATE, 8'(sy), "state");
    rdchk(efs_pkg::IDX_SYNC_EN, 8'h00, "sync_en");
    rdchk(efs_pkg::IDX_EVT_EN, 8'h00, "evt_en");
    rdchk(efs_pkg::IDX_SYNC_FLG, 8'h00, "sync_flg");
    rdchk(efs_pkg::IDX_EVT_FLG, 8'h00, "evt_flg");
    e = $urandom;
    bus(1'b1, efs_pkg::IDX_SYNC_EN, 8'hff, q);
    rdchk(efs_pkg::IDX_SYNC_EN, efs_pkg::SYNC_EN_MASK, "sync_en_mask");
    bus(1'b1, efs_pkg::IDX_EVT_EN, e[7:0], q);
    rdchk(efs_pkg::IDX_EVT_EN, e[7:0], "evt_en_rw");
    bus(1'b1, 10'h060, 8'hff, q);
    rdchk(10'h060, 8'h00, "unmapped");
    bus(1'b1, efs_pkg::IDX_STATE, 8'hff, q);
    rdchk(efs_pkg::IDX_STATE, 8'(sy), "state_ro");
    bus(1'b1, efs_pkg::IDX_SYNC_EN, 8'h00, q);
    bus(1'b1, efs_pkg::IDX_EVT_EN, 8'h00, q);
    ce <= 1'b0;
    sy[1] <= 1'b1;
    repeat (2) @(posedge clk);
    sy[1] <= 1'b0;
    ce <= 1'b1;
    rdchk(efs_pkg::IDX_SYNC_FLG, 8'h00, "ce_freeze");
    $display("test registers done");
    for (int i = 0; i < 5; i++) begin
      for (int k = 0; k < 2; k++) begin
        sy[i] <= ~sy[i];
        repeat (3) @(posedge clk);
        rdchk(efs_pkg::IDX_STATE, 8'(sy), "state_live");
        rdchk(efs_pkg::IDX_SYNC_FLG, 8'(1 << i), "sync_flg");
        pin(1'b1, "int_masked");
        bus(1'b1, efs_pkg::IDX_SYNC_FLG, 8'h00, q);
        bus(1'b1, efs_pkg::IDX_SYNC_EN, 8'(1 << i), q);
        repeat (2) @(posedge clk);
        pin(1'b0, "int_on");
        bus(1'b1, efs_pkg::IDX_SYNC_FLG, 8'(1 << i), q);
        bus(1'b1, efs_pkg::IDX_SYNC_EN, 8'h00, q);
        repeat (2) @(posedge clk);
        pin(1'b1, "int_off");
        rdchk(efs_pkg::IDX_SYNC_FLG, 8'h00, "sync_clr");
      end
    end
    $display("test sync changes done");
    sy <= 5'h00;
    nflip <= 1'b1;
    bus(1'b1, efs_pkg::IDX_SYNC_FLG, 8'h3f, q);
    for (int m = 0; m < 4; m++) begin
      flip <= 7'($urandom_range(127, 1));
      bus(1'b1, efs_pkg::IDX_MODE, 8'he0 | 8'(m << 3), q);
      bus(1'b1, efs_pkg::IDX_EVT_FLG, 8'hff, q);
      run_mf();
      e = m[0] ? 1 : $countones(flip);
      chk("err_count", 16'(8 * (e + m[1])), acc);
      bus(1'b0, efs_pkg::IDX_EVT_FLG, 8'h00, q);
      chk("evt_locked", 16'h00d2, 16'(q & 8'hfb));
    end
    $display("test locked multiframes done");
    sy <= 5'h0d;
    bus(1'b1, efs_pkg::IDX_SYNC_FLG, 8'h3f, q);
    bus(1'b1, efs_pkg::IDX_EVT_FLG, 8'hff, q);
    run_mf();
    chk("err_unlocked", 16'h0, acc);
    bus(1'b0, efs_pkg::IDX_EVT_FLG, 8'h00, q);
    chk("evt_unlocked", 16'h0, 16'(q));
    $display("test unlocked multiframe done");
    e = $urandom_range(254, 0);
    for (int k = 0; k < 3; k++) begin
      afound <= 1'b1;
      apos <= 8'(e + (k == 2));
      @(posedge clk);
      afound <= 1'b0;
      repeat (2) @(posedge clk);
      bus(1'b0, efs_pkg::IDX_EVT_FLG, 8'h00, q);
      chk("align_shift", 16'(k == 2), 16'(q));
    end
    $display("test align shift done");
    results();
  end
endmodule : tb_efs_top
bind efs_top efs_assertions u_efs_assertions (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .ce_in(ce_in),
  .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
  .avs_readdata_out(avs_readdata_out), .avs_waitrequest_out(avs_waitrequest_out),
  .basic_frame_unlocked_in(basic_frame_unlocked_in), .offline_frame_unlocked_in(offline_frame_unlocked_in),
  .crcmf_unlocked_in(crcmf_unlocked_in), .sigmf_unlocked_in(sigmf_unlocked_in),
  .interwork_active_in(interwork_active_in), .rx_bit_en_in(rx_bit_en_in),
  .fas_err_num_out(fas_err_num_out), .int_n_out(int_n_out));
